/* verilog/rx_alarm_irq_pkg.sv */
// Register map, field positions and reset values of the receive alarm interrupt block
package rx_alarm_irq_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_LOOPBACK_STATUS = 8'h0a;
	localparam logic [7:0] OFS_LOOPBACK_ENABLE = 8'h0b;
	localparam logic [7:0] OFS_EXCESS_ZERO_STATUS = 8'h0f;
	localparam logic [7:0] OFS_EXCESS_ZERO_ENABLE = 8'h11;
	localparam logic [7:0] OFS_LAPD1_STATUS = 8'h11 + 8'h02;
	localparam logic [7:0] OFS_LAPD1_ENABLE = 8'h14;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_ACT_STATE = 3;
	localparam int BIT_DEACT_STATE = 2;
	localparam int BIT_ACT = 1;
	localparam int BIT_DEACT = 0;
	localparam int BIT_EXZ = 0;
	localparam int BIT_LAPD1 = 0;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RESET_FLAG = 1'b0;
	localparam logic RESET_ENABLE = 1'b0;
	localparam logic [7:0] READ_ZERO = 8'h00;
endpackage

/* verilog/level_sync.sv */
// Three-stage synchroniser with second/third agreement filter
`timescale 1ns/1ps
module level_sync (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_enable,
	// Raw level and filtered result
	input wire logic i_level,
	output logic o_level
);
	typedef struct packed {
		logic meta;
		logic s2;
		logic s3;
		logic out;
	} state_type;
	state_type state;
	state_type next_state;

	always_comb begin
		next_state = state;
		next_state.meta = i_level;
		next_state.s2 = state.meta;
		next_state.s3 = state.s2;
		// A change counts only once two late stages agree
		if (state.s2 == state.s3) begin
			next_state.out = state.s3;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state <= '0;
		end else if (i_enable) begin
			state <= next_state;
		end
	end

	assign o_level = state.out;
endmodule

/* verilog/sticky_flag.sv */
// One sticky interrupt flag: set wins over clear-on-read
`timescale 1ns/1ps
module sticky_flag (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_enable,
	// Event and clear
	input wire logic i_set,
	input wire logic i_clear,
	output logic o_flag
);
	typedef struct packed {
		logic flag;
	} state_type;
	state_type state;
	state_type next_state;

	always_comb begin
		next_state = state;
		if (i_set) begin
			next_state.flag = 1'b1;
		end else if (i_clear) begin
			next_state.flag = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state.flag <= rx_alarm_irq_pkg::RESET_FLAG;
		end else if (i_enable) begin
			state <= next_state;
		end
	end

	assign o_flag = state.flag;
endmodule

/* verilog/rx_alarm_irq.sv */
// Receive alarm interrupt status and enable registers with interrupt output
// What this block does
// - Activation-code change interrupt gated by enable bit 1
// - Deactivation-code change interrupt gated by enable bit 0
// - Excess-zero flag sets on condition start and end
// - Excess-zero flag reads, then clears to zero
// - Excess-zero enable bit 0, reset zero
// - Long LAPD message sets clear-on-read flag
// - Long-message enable bit 0, reset zero
`timescale 1ns/1ps
module rx_alarm_irq (
	// Clock, reset, clock enable
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_enable,
	// Register port
	input wire logic [rx_alarm_irq_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rx_alarm_irq_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [rx_alarm_irq_pkg::DATA_W-1:0] o_rdata,
	// Detector levels and events from the receive framer (pins)
	input wire logic i_activation_code_detect,
	input wire logic i_deactivation_code_detect,
	input wire logic i_excess_zero_detect,
	input wire logic i_lapd1_long_message,
	// Interrupt
	output logic o_irq
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic act_prev;
		logic deact_prev;
		logic exz_prev;
		logic lapd_prev;
		logic primed;
		logic activation_code_change_irq_en;
		logic deactivation_code_change_irq_en;
		logic excess_zero_change_irq_en;
		logic lapd1_long_message_irq_en;
		logic [rx_alarm_irq_pkg::DATA_W-1:0] rdata;
	} state_type;
	state_type state;
	state_type next_state;

	logic act_lvl;
	logic deact_lvl;
	logic exz_lvl;
	logic lapd_lvl;
	logic act_flag;
	logic deact_flag;
	logic excess_zero_change_flag;
	logic lapd1_long_message_flag;
	logic act_set;
	logic deact_set;
	logic exz_set;
	logic lapd_set;
	logic clr_loopback;
	logic clr_exz;
	logic clr_lapd;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	level_sync u_sync_act (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_level(i_activation_code_detect),
		.o_level(act_lvl)
	);
	level_sync u_sync_deact (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_level(i_deactivation_code_detect),
		.o_level(deact_lvl)
	);
	level_sync u_sync_exz (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_level(i_excess_zero_detect),
		.o_level(exz_lvl)
	);
	level_sync u_sync_lapd (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_level(i_lapd1_long_message),
		.o_level(lapd_lvl)
	);

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	// Priming skips the first compare so reset levels raise no false change
	assign act_set = state.primed && (act_lvl != state.act_prev);
	assign deact_set = state.primed && (deact_lvl != state.deact_prev);
	assign exz_set = state.primed && (exz_lvl != state.exz_prev);
	// Long-message indication is a level; its rising edge is one message
	assign lapd_set = state.primed && lapd_lvl && !state.lapd_prev;

	assign clr_loopback = i_read && (i_addr == rx_alarm_irq_pkg::OFS_LOOPBACK_STATUS);
	assign clr_exz = i_read && (i_addr == rx_alarm_irq_pkg::OFS_EXCESS_ZERO_STATUS);
	assign clr_lapd = i_read && (i_addr == rx_alarm_irq_pkg::OFS_LAPD1_STATUS);

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	sticky_flag u_flag_act (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_set(act_set),
		.i_clear(clr_loopback),
		.o_flag(act_flag)
	);
	sticky_flag u_flag_deact (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_set(deact_set),
		.i_clear(clr_loopback),
		.o_flag(deact_flag)
	);
	sticky_flag u_flag_exz (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_set(exz_set),
		.i_clear(clr_exz),
		.o_flag(excess_zero_change_flag)
	);
	sticky_flag u_flag_lapd (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(i_enable),
		.i_set(lapd_set),
		.i_clear(clr_lapd),
		.o_flag(lapd1_long_message_flag)
	);

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_state.act_prev = act_lvl;
		next_state.deact_prev = deact_lvl;
		next_state.exz_prev = exz_lvl;
		next_state.lapd_prev = lapd_lvl;
		next_state.primed = 1'b1;
		if (i_write) begin
			case (i_addr)
				rx_alarm_irq_pkg::OFS_LOOPBACK_ENABLE: begin
					next_state.activation_code_change_irq_en =
						i_wdata[rx_alarm_irq_pkg::BIT_ACT];
					next_state.deactivation_code_change_irq_en =
						i_wdata[rx_alarm_irq_pkg::BIT_DEACT];
				end
				rx_alarm_irq_pkg::OFS_EXCESS_ZERO_ENABLE: begin
					next_state.excess_zero_change_irq_en =
						i_wdata[rx_alarm_irq_pkg::BIT_EXZ];
				end
				rx_alarm_irq_pkg::OFS_LAPD1_ENABLE: begin
					next_state.lapd1_long_message_irq_en =
						i_wdata[rx_alarm_irq_pkg::BIT_LAPD1];
				end
				default: begin
				end
			endcase
		end
		// Reserved bits and unmapped offsets read zero
		next_state.rdata = rx_alarm_irq_pkg::READ_ZERO;
		if (i_read) begin
			case (i_addr)
				rx_alarm_irq_pkg::OFS_LOOPBACK_STATUS: begin
					next_state.rdata[rx_alarm_irq_pkg::BIT_ACT_STATE] = act_lvl;
					next_state.rdata[rx_alarm_irq_pkg::BIT_DEACT_STATE] = deact_lvl;
					next_state.rdata[rx_alarm_irq_pkg::BIT_ACT] = act_flag;
					next_state.rdata[rx_alarm_irq_pkg::BIT_DEACT] = deact_flag;
				end
				rx_alarm_irq_pkg::OFS_LOOPBACK_ENABLE: begin
					next_state.rdata[rx_alarm_irq_pkg::BIT_ACT] =
						state.activation_code_change_irq_en;
					next_state.rdata[rx_alarm_irq_pkg::BIT_DEACT] =
						state.deactivation_code_change_irq_en;
				end
				rx_alarm_irq_pkg::OFS_EXCESS_ZERO_STATUS: begin
					next_state.rdata[rx_alarm_irq_pkg::BIT_EXZ] =
						excess_zero_change_flag;
				end
				rx_alarm_irq_pkg::OFS_EXCESS_ZERO_ENABLE: begin
					next_state.rdata[rx_alarm_irq_pkg::BIT_EXZ] =
						state.excess_zero_change_irq_en;
				end
				rx_alarm_irq_pkg::OFS_LAPD1_STATUS: begin
					next_state.rdata[rx_alarm_irq_pkg::BIT_LAPD1] = lapd1_long_message_flag;
				end
				rx_alarm_irq_pkg::OFS_LAPD1_ENABLE: begin
					next_state.rdata[rx_alarm_irq_pkg::BIT_LAPD1] =
						state.lapd1_long_message_irq_en;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state <= '0;
			state.activation_code_change_irq_en <= rx_alarm_irq_pkg::RESET_ENABLE;
			state.deactivation_code_change_irq_en <= rx_alarm_irq_pkg::RESET_ENABLE;
			state.excess_zero_change_irq_en <= rx_alarm_irq_pkg::RESET_ENABLE;
			state.lapd1_long_message_irq_en <= rx_alarm_irq_pkg::RESET_ENABLE;
		end else if (i_enable) begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_rdata = state.rdata;
	// Level output straight from flag and enable flip-flops
	assign o_irq = (act_flag && state.activation_code_change_irq_en)
		|| (deact_flag && state.deactivation_code_change_irq_en)
		|| (excess_zero_change_flag && state.excess_zero_change_irq_en)
		|| (lapd1_long_message_flag && state.lapd1_long_message_irq_en);
endmodule

/* sim/rx_alarm_irq_sva.sv */
// Concurrent checks for the receive alarm interrupt block
`timescale 1ns/1ps
module rx_alarm_irq_sva (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic [7:0] o_rdata,
	input wire logic i_activation_code_detect,
	input wire logic i_deactivation_code_detect,
	input wire logic i_excess_zero_detect,
	input wire logic i_lapd1_long_message,
	input wire logic o_irq
);
	localparam logic [7:0] ZS = rx_alarm_irq_pkg::OFS_EXCESS_ZERO_STATUS;
	localparam logic [7:0] ZE = rx_alarm_irq_pkg::OFS_EXCESS_ZERO_ENABLE;
	logic [3:0] en;
	logic [3:0] det;
	logic [3:0] det_q;
	logic [3:0] quiet;
	assign det = {i_lapd1_long_message, i_excess_zero_detect,
		i_deactivation_code_detect, i_activation_code_detect};
	// Quiet saturates at 8, well past the synchroniser depth
	always_ff @(posedge i_clock) begin
		det_q <= det;
		if (!i_rst_n) begin
			en <= 4'h0;
			quiet <= 4'h0;
		end else if (i_enable) begin
			// A frozen block takes no write, so the model follows the enable
			en[1:0] <= (i_write && i_addr == 8'h0b) ? i_wdata[1:0] : en[1:0];
			en[2] <= (i_write && i_addr == ZE) ? i_wdata[0] : en[2];
			en[3] <= (i_write && i_addr == 8'h14) ? i_wdata[0] : en[3];
			quiet <= (det != det_q) ? 4'h0 : quiet + {3'h0, !quiet[3]};
		end
	end
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);
	chk_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 8'h00)
		else $error("rdata not idle");
	chk_zero_enable: assert property (i_read && i_addr == ZE |=> o_rdata == {7'h00, en[2]})
		else $error("enable readback");
	chk_irq_needs_en: assert property (en == 4'h0 |-> !o_irq)
		else $error("irq unenabled");
	chk_act_event: assert property ($changed(det[0]) && en[1] |-> ##[2:10] o_irq)
		else $error("no act irq");
	chk_zero_event: assert property ($changed(det[2]) && en[2] |-> ##[2:10] o_irq)
		else $error("no zero irq");
	chk_lapd_event: assert property ($rose(det[3]) && en[3] |-> ##[2:10] o_irq)
		else $error("no lapd irq");
	chk_read_clears: assert property (i_read && i_addr == ZS && en[1:0] == 2'h0 && !en[3]
		&& quiet[3] |=> !o_irq) else $error("irq after read");
	chk_irq_steady: assert property (quiet[3] && !i_read && !i_write |=> $stable(o_irq))
		else $error("irq moved");
	cover property (i_read && i_addr == ZS ##1 o_rdata[0]);
	cover property ($rose(o_irq));
	cover property ($fell(o_irq));
endmodule

/* sim/test_rx_alarm_irq.sv */
// Self-checking bench for the receive alarm interrupt block
`timescale 1ns/1ps
module test_rx_alarm_irq;
	localparam logic [7:0] ALL [7] = '{rx_alarm_irq_pkg::OFS_LOOPBACK_STATUS,
		rx_alarm_irq_pkg::OFS_LOOPBACK_ENABLE, rx_alarm_irq_pkg::OFS_EXCESS_ZERO_STATUS,
		rx_alarm_irq_pkg::OFS_EXCESS_ZERO_ENABLE, rx_alarm_irq_pkg::OFS_LAPD1_STATUS,
		rx_alarm_irq_pkg::OFS_LAPD1_ENABLE, 8'hff};
	localparam logic [7:0] WM [7] = '{8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
	localparam int SI [4] = '{0, 0, 2, 4};
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_enable = 1'b1;
	logic i_write = 1'b0;
	logic i_read = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic [7:0] o_rdata;
	logic o_irq;
	logic [3:0] det = 4'h0;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	int n_errors = 0;
	int samples_checked = 0;
	always #2 i_clock = ~i_clock;
	rx_alarm_irq i_rx_alarm_irq (
		.i_clock, .i_rst_n, .i_enable, .i_addr, .i_wdata, .i_write, .i_read,
		.o_rdata, .i_activation_code_detect(det[0]), .i_deactivation_code_detect(det[1]),
		.i_excess_zero_detect(det[2]), .i_lapd1_long_message(det[3]), .o_irq
	);
	task automatic check(input logic [7:0] seen, input logic [7:0] expv);
		samples_checked++;
		if (seen !== expv) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, seen, expv);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// A read notes its expected data for the monitor
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		if (!w) exp_q.push_back(d);
		i_write <= w;
		i_read <= !w;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
	endtask
	task automatic idle(input int n);
		i_read <= 1'b0;
		i_write <= 1'b0;
		repeat (n) @(posedge i_clock);
	endtask
	always @(posedge i_clock) rd_d <= i_read;
	always @(negedge i_clock) begin
		if (rd_d) begin
			check(o_rdata, exp_q.pop_front());
		end
	end
	initial begin
		logic [7:0] d;
		logic [7:0] b;
		logic [7:0] m;
		void'($urandom(32'h29685782));
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		foreach (ALL[i]) bus(1'b0, ALL[i], 8'h00);
		repeat (3) begin
			foreach (ALL[i]) begin
				d = 8'($urandom);
				bus(1'b1, ALL[i], d);
				bus(1'b0, ALL[i], d & WM[i]);
			end
		end
		foreach (ALL[i]) bus(1'b1, ALL[i], 8'h00);
		// A write while the clock enable is low must not land
		i_enable <= 1'b0;
		bus(1'b1, ALL[3], 8'h01);
		i_enable <= 1'b1;
		idle(1);
		bus(1'b0, ALL[3], 8'h00);
		// Each event once masked, once enabled; level events toggle both ways
		for (int k = 0; k < 4; k++) begin
			m = (k == 0) ? 8'h02 : 8'h01;
			for (int p = 0; p < 2; p++) begin
				bus(1'b1, ALL[SI[k] + 1], p ? m : 8'h00);
				det[k] <= !det[k];
				idle(4);
				det[3] <= 1'b0;
				idle(12);
				check({7'h00, o_irq}, 8'(p));
				b = (k < 2) ? {4'h0, det[0], det[1], 2'h0} : 8'h00;
				bus(1'b0, ALL[SI[k]], b | m);
				bus(1'b0, ALL[SI[k]], b);
				idle(1);
				check({7'h00, o_irq}, 8'h00);
			end
			bus(1'b1, ALL[SI[k] + 1], 8'h00);
		end
		idle(2);
		give_verdict();
	end
	initial begin
		repeat (3000) @(posedge i_clock);
		n_errors++;
		give_verdict();
	end
endmodule
bind rx_alarm_irq rx_alarm_irq_sva i_rx_alarm_irq_sva (
	.i_clock, .i_rst_n, .i_enable, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
	.i_activation_code_detect, .i_deactivation_code_detect, .i_excess_zero_detect,
	.i_lapd1_long_message, .o_irq
);
